/* logic/rfpo_regs.sv */
// rf power override register bank with axi4-lite slave and enable decode
// Functional notes
// [R1] synth reset follows the sequencer on 1/1, released on select 1 clear 0, held on 0/1.
// [R2] oscillator buffer enable follows the sequencer on 1/1, off on 0/1, else on.
// [R3] divider enable is off only for power-up 1 power-down 0, sequencer on 1/1, else on.
// [R4] charge pump enable uses the same pair decode as every other circuit.
// [R5] low noise amp enable follows the sequencer on 1/1, off on 0/1, else on.
// [R6] baseband amp enable uses the pair decode and is forced off only for 0/1.
// [R7] receive mixer enable follows the sequencer on 1/1, off on 0/1, else on.
// [R8] receive mixer buffer enable follows the sequencer on 1/1, off on 0/1, else on.
// [R9] gain amp enable is off for 0/1, sequencer on 1/1, else on.
// [R10] receive converter enable follows the sequencer on 1/1, off on 0/1, else on.
// [R11] transmit up-mixer buffer enable follows the sequencer on 1/1, off on 0/1, else on.
// [R12] software keeps the reserved receive power-down bit 3 written as zero.
// [R13] reset loads power-down bits 0, power-up and clear bits 1, reserved bits their defaults.
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module rfpo_regs (
    input  wire logic                      clock,
    input  wire logic                      rst_b,
    input  wire rfpo_pkg::rfpo_axi_req_type axiReq,
    output      rfpo_pkg::rfpo_axi_rsp_type axiRsp,
    input  wire logic [11:0]               modemEnable,
    input  wire logic                      modemSynthReset,
    output      logic [11:0]               circuitEnable_ff,
    output      logic                      synthReset_ff
);
    import rfpo_pkg::*;

    logic [7:0]  regs_ff [NUM_REGS];
    logic [7:0]  nxt_regs [NUM_REGS];
    logic        awHeld_ff;
    logic        nxt_awHeld;
    logic [31:0] awAddr_ff;
    logic [31:0] nxt_awAddr;
    logic        wHeld_ff;
    logic        nxt_wHeld;
    logic [7:0]  wData_ff;
    logic [7:0]  nxt_wData;
    logic        wLane_ff;
    logic        nxt_wLane;
    rfpo_axi_rsp_type rsp_ff;
    rfpo_axi_rsp_type nxt_rsp;
    logic        writeFire;
    logic        writeHit;
    logic [2:0]  writeIdx;
    logic        readHit;
    logic [2:0]  readIdx;
    logic [11:0] downVec;
    logic [11:0] upVec;
    logic [11:0] nxt_circuitEnable;
    logic        nxt_synthReset;

    assign axiRsp = rsp_ff;

    // only six aligned words exist; anything else answers slverr
    always_comb begin
        writeIdx = awAddr_ff[4:2];
        writeHit = (awAddr_ff[31:5] == 27'h0) && (awAddr_ff[1:0] == 2'h0)
                   && (writeIdx <= IDX_TX_PU);
        readIdx  = axiReq.araddr[4:2];
        readHit  = (axiReq.araddr[31:5] == 27'h0) && (axiReq.araddr[1:0] == 2'h0)
                   && (readIdx <= IDX_TX_PU);
        writeFire = awHeld_ff && wHeld_ff && !rsp_ff.bvalid;
    end

    always_comb begin
        nxt_awHeld = awHeld_ff;
        nxt_awAddr = awAddr_ff;
        nxt_wHeld  = wHeld_ff;
        nxt_wData  = wData_ff;
        nxt_wLane  = wLane_ff;
        nxt_rsp    = rsp_ff;
        for (int i = 0; i < NUM_REGS; i++) begin
            nxt_regs[i] = regs_ff[i];
        end
        if (rsp_ff.awready && axiReq.awvalid) begin
            nxt_awHeld = 1'b1;
            nxt_awAddr = axiReq.awaddr;
        end
        if (rsp_ff.wready && axiReq.wvalid) begin
            nxt_wHeld = 1'b1;
            nxt_wData = axiReq.wdata[7:0];
            nxt_wLane = axiReq.wstrb[0];
        end
        if (rsp_ff.bvalid && axiReq.bready) begin
            nxt_rsp.bvalid = 1'b0;
        end
        // address and data may land in either order; commit once both are held
        if (writeFire) begin
            nxt_awHeld     = 1'b0;
            nxt_wHeld      = 1'b0;
            nxt_rsp.bvalid = 1'b1;
            nxt_rsp.bresp  = writeHit ? RESP_OKAY : RESP_SLVERR;
            // [R12] reserved bits stored as written
            if (writeHit && wLane_ff) begin
                nxt_regs[writeIdx] = wData_ff;
            end
        end
        nxt_rsp.awready = !nxt_awHeld;
        nxt_rsp.wready  = !nxt_wHeld;
        if (rsp_ff.rvalid && axiReq.rready) begin
            nxt_rsp.rvalid = 1'b0;
        end
        if (rsp_ff.arready && axiReq.arvalid) begin
            nxt_rsp.rvalid = 1'b1;
            nxt_rsp.rdata  = readHit ? {24'h0, regs_ff[readIdx]} : 32'h0;
            nxt_rsp.rresp  = readHit ? RESP_OKAY : RESP_SLVERR;
        end
        nxt_rsp.arready = !nxt_rsp.rvalid;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            awHeld_ff <= 1'b0;
            awAddr_ff <= 32'h0;
            wHeld_ff  <= 1'b0;
            wData_ff  <= 8'h0;
            wLane_ff  <= 1'b0;
            rsp_ff    <= '0;
            // [R13] power-on values
            regs_ff[IDX_PLL_PD] <= RST_PLL_PD;
            regs_ff[IDX_PLL_PU] <= RST_PLL_PU;
            regs_ff[IDX_RX_PD]  <= RST_RX_PD;
            regs_ff[IDX_RX_PU]  <= RST_RX_PU;
            regs_ff[IDX_TX_PD]  <= RST_TX_PD;
            regs_ff[IDX_TX_PU]  <= RST_TX_PU;
        end else begin
            awHeld_ff <= nxt_awHeld;
            awAddr_ff <= nxt_awAddr;
            wHeld_ff  <= nxt_wHeld;
            wData_ff  <= nxt_wData;
            wLane_ff  <= nxt_wLane;
            rsp_ff    <= nxt_rsp;
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_ff[i] <= nxt_regs[i];
            end
        end
    end

    // gather the pairs into one vector so a single decode serves all circuits
    always_comb begin
        downVec = {regs_ff[IDX_TX_PD][BIT_TX_UPMIX_BUF],
                   regs_ff[IDX_RX_PD][BIT_LOW_NOISE_AMP],
                   regs_ff[IDX_RX_PD][BIT_RX_MIXER],
                   regs_ff[IDX_RX_PD][BIT_BASEBAND_AMP],
                   regs_ff[IDX_RX_PD][BIT_RX_MIXER_BUF],
                   regs_ff[IDX_RX_PD][BIT_RX_LOWPASS],
                   regs_ff[IDX_RX_PD][BIT_GAIN_AMP],
                   regs_ff[IDX_RX_PD][BIT_RX_CONVERTER],
                   regs_ff[IDX_PLL_PD][BIT_OSC_BUFFER],
                   regs_ff[IDX_PLL_PD][BIT_OSC],
                   regs_ff[IDX_PLL_PD][BIT_FREQ_DIVIDER],
                   regs_ff[IDX_PLL_PD][BIT_CHARGE_PUMP]};
        upVec   = {regs_ff[IDX_TX_PU][BIT_TX_UPMIX_BUF],
                   regs_ff[IDX_RX_PU][BIT_LOW_NOISE_AMP],
                   regs_ff[IDX_RX_PU][BIT_RX_MIXER],
                   regs_ff[IDX_RX_PU][BIT_BASEBAND_AMP],
                   regs_ff[IDX_RX_PU][BIT_RX_MIXER_BUF],
                   regs_ff[IDX_RX_PU][BIT_RX_LOWPASS],
                   regs_ff[IDX_RX_PU][BIT_GAIN_AMP],
                   regs_ff[IDX_RX_PU][BIT_RX_CONVERTER],
                   regs_ff[IDX_PLL_PU][BIT_OSC_BUFFER],
                   regs_ff[IDX_PLL_PU][BIT_OSC],
                   regs_ff[IDX_PLL_PU][BIT_FREQ_DIVIDER],
                   regs_ff[IDX_PLL_PU][BIT_CHARGE_PUMP]};
    end

    // [R2] [R3] [R4] [R5] [R6] [R7] [R8] [R9] [R10] [R11] shared pair decode
    for (genvar g = 0; g < NUM_CIRCUITS; g++) begin : gDecode
        always_comb begin
            nxt_circuitEnable[g] = rfpo_pair_enable(downVec[g], upVec[g], modemEnable[g]);
        end
    end

    // [R1] synth reset decode; 0/0 treated as released
    always_comb begin
        case ({regs_ff[IDX_PLL_PD][BIT_SYNTH_RESET], regs_ff[IDX_PLL_PU][BIT_SYNTH_RESET]})
            2'h3:    nxt_synthReset = modemSynthReset;
            2'h1:    nxt_synthReset = 1'b1;
            default: nxt_synthReset = 1'b0;
        endcase
    end

    // registered so the analog enables never glitch while the bus writes
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            // same as the reset pairs decode, so no power-on glitch at release
            circuitEnable_ff <= RST_CIRCUIT_EN;
            synthReset_ff    <= RST_SYNTH_RESET;
        end else begin
            circuitEnable_ff <= nxt_circuitEnable;
            synthReset_ff    <= nxt_synthReset;
        end
    end

    logic seenEdge_ff;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            seenEdge_ff <= 1'b0;
        end else begin
            seenEdge_ff <= 1'b1;
        end
    end

    sequence offWrite_s(logic [2:0] idx, int unsigned bitPos);
        writeFire && writeHit && wLane_ff && (writeIdx == idx) && wData_ff[bitPos]
        && !regs_ff[idx - 3'h1][bitPos];
    endsequence

    sequence handedBack_s(logic [2:0] idx, int unsigned bitPos);
        writeFire && writeHit && wLane_ff && (writeIdx == idx) && wData_ff[bitPos]
        && regs_ff[idx + 3'h1][bitPos];
    endsequence

    synthResetDecode_a: assert property (@(posedge clock) disable iff (!rst_b) // [R1]
        ({$past(regs_ff[IDX_PLL_PD][BIT_SYNTH_RESET]), $past(regs_ff[IDX_PLL_PU][BIT_SYNTH_RESET])}
         == 2'h1) |-> synthReset_ff)
        else $error("synth reset not held for select 0 clear 1");

    synthResetModem_a: assert property (@(posedge clock) disable iff (!rst_b) // [R1]
        (regs_ff[IDX_PLL_PD][BIT_SYNTH_RESET] && regs_ff[IDX_PLL_PU][BIT_SYNTH_RESET])
        |=> synthReset_ff == $past(modemSynthReset))
        else $error("synth reset does not follow sequencer");

    oscBufferOff_a: assert property (@(posedge clock) disable iff (!rst_b) // [R2]
        offWrite_s(IDX_PLL_PU, BIT_OSC_BUFFER) |-> ##2 !circuitEnable_ff[EN_OSC_BUFFER])
        else $error("osc buffer not forced off after write");

    dividerDecode_a: assert property (@(posedge clock) disable iff (!rst_b) // [R3]
        !(!downVec[EN_FREQ_DIVIDER] && upVec[EN_FREQ_DIVIDER]) && !downVec[EN_FREQ_DIVIDER]
        |=> circuitEnable_ff[EN_FREQ_DIVIDER])
        else $error("divider not forced on");

    chargePumpOn_a: assert property (@(posedge clock) disable iff (!rst_b) // [R4]
        (downVec[EN_CHARGE_PUMP] && !upVec[EN_CHARGE_PUMP]) [*2]
        |-> circuitEnable_ff[EN_CHARGE_PUMP])
        else $error("charge pump not forced on for 1/0");

    lowNoiseModem_a: assert property (@(posedge clock) disable iff (!rst_b) // [R5]
        handedBack_s(IDX_RX_PD, BIT_LOW_NOISE_AMP)
        |-> ##2 circuitEnable_ff[EN_LOW_NOISE_AMP] == $past(modemEnable[EN_LOW_NOISE_AMP]))
        else $error("low noise amp not under sequencer");

    basebandOff_a: assert property (@(posedge clock) disable iff (!rst_b) // [R6]
        !circuitEnable_ff[EN_BASEBAND_AMP] |->
        $past(!downVec[EN_BASEBAND_AMP] && upVec[EN_BASEBAND_AMP])
        || $past(downVec[EN_BASEBAND_AMP] && upVec[EN_BASEBAND_AMP]))
        else $error("baseband amp off without cause");

    rxMixerDecode_a: assert property (@(posedge clock) disable iff (!rst_b) // [R7]
        circuitEnable_ff[EN_RX_MIXER] == rfpo_pair_enable($past(downVec[EN_RX_MIXER]),
        $past(upVec[EN_RX_MIXER]), $past(modemEnable[EN_RX_MIXER])))
        else $error("rx mixer enable wrong");

    mixerBufOff_a: assert property (@(posedge clock) disable iff (!rst_b) // [R8]
        offWrite_s(IDX_RX_PU, BIT_RX_MIXER_BUF) |-> ##2 !circuitEnable_ff[EN_RX_MIXER_BUF])
        else $error("rx mixer buffer not forced off");

    gainAmpOn_a: assert property (@(posedge clock) disable iff (!rst_b) // [R9]
        !upVec[EN_GAIN_AMP] |=> circuitEnable_ff[EN_GAIN_AMP])
        else $error("gain amp not forced on");

    converterDecode_a: assert property (@(posedge clock) disable iff (!rst_b) // [R10]
        (!downVec[EN_RX_CONVERTER] && upVec[EN_RX_CONVERTER])
        |=> !circuitEnable_ff[EN_RX_CONVERTER])
        else $error("rx converter not forced off");

    upmixBufModem_a: assert property (@(posedge clock) disable iff (!rst_b) // [R11]
        handedBack_s(IDX_TX_PD, BIT_TX_UPMIX_BUF)
        |-> ##2 circuitEnable_ff[EN_TX_UPMIX_BUF] == $past(modemEnable[EN_TX_UPMIX_BUF]))
        else $error("tx upmixer buffer not under sequencer");

    resetValues_a: assert property (@(posedge clock) disable iff (!rst_b) // [R13]
        !seenEdge_ff |-> regs_ff[IDX_PLL_PD] == RST_PLL_PD && regs_ff[IDX_PLL_PU] == RST_PLL_PU
        && regs_ff[IDX_RX_PD] == RST_RX_PD && regs_ff[IDX_RX_PU] == RST_RX_PU
        && regs_ff[IDX_TX_PD] == RST_TX_PD && regs_ff[IDX_TX_PU] == RST_TX_PU
        && circuitEnable_ff == RST_CIRCUIT_EN && synthReset_ff == RST_SYNTH_RESET)
        else $error("registers not at reset values");

    writeAnswer_a: assert property (@(posedge clock) disable iff (!rst_b)
        writeFire |=> rsp_ff.bvalid)
        else $error("write not answered");

    synthResetFree_a: assert property (@(posedge clock) disable iff (!rst_b) // [R1]
        ({$past(regs_ff[IDX_PLL_PD][BIT_SYNTH_RESET]), $past(regs_ff[IDX_PLL_PU][BIT_SYNTH_RESET])}
         == 2'h2) |-> !synthReset_ff)
        else $error("synth reset not released for select 1 clear 0");

    upmixBufOff_a: assert property (@(posedge clock) disable iff (!rst_b) // [R11]
        (!downVec[EN_TX_UPMIX_BUF] && upVec[EN_TX_UPMIX_BUF])
        |=> !circuitEnable_ff[EN_TX_UPMIX_BUF])
        else $error("tx upmixer buffer not forced off");

    readAnswer_a: assert property (@(posedge clock) disable iff (!rst_b)
        (rsp_ff.arready && axiReq.arvalid) |=> rsp_ff.rvalid && !rsp_ff.arready)
        else $error("read not answered");

    writeMiss_a: assert property (@(posedge clock) disable iff (!rst_b)
        (writeFire && !writeHit) |=> rsp_ff.bvalid && rsp_ff.bresp == RESP_SLVERR)
        else $error("unmapped write not refused");

    readMiss_a: assert property (@(posedge clock) disable iff (!rst_b)
        (rsp_ff.arready && axiReq.arvalid && !readHit)
        |=> rsp_ff.rresp == RESP_SLVERR && rsp_ff.rdata == 32'h0)
        else $error("unmapped read not refused");

endmodule

/* logic/rfpo_pkg.sv */
// register map, reset values, bit positions and bus carriers of the rf power override bank
package rfpo_pkg;

    localparam int unsigned NUM_REGS      = 6;
    localparam int unsigned NUM_CIRCUITS  = 12;

    localparam logic [31:0] OFS_PLL_PD    = 32'h0000_0000;
    localparam logic [31:0] OFS_PLL_PU    = 32'h0000_0004;
    localparam logic [31:0] OFS_RX_PD     = 32'h0000_0008;
    localparam logic [31:0] OFS_RX_PU     = 32'h0000_000c;
    localparam logic [31:0] OFS_TX_PD     = 32'h0000_0010;
    localparam logic [31:0] OFS_TX_PU     = 32'h0000_0014;

    localparam logic [2:0]  IDX_PLL_PD    = 3'h0;
    localparam logic [2:0]  IDX_PLL_PU    = 3'h1;
    localparam logic [2:0]  IDX_RX_PD     = 3'h2;
    localparam logic [2:0]  IDX_RX_PU     = 3'h3;
    localparam logic [2:0]  IDX_TX_PD     = 3'h4;
    localparam logic [2:0]  IDX_TX_PU     = 3'h5;

    localparam logic [7:0]  RST_PLL_PD    = 8'he0;
    localparam logic [7:0]  RST_PLL_PU    = 8'hff;
    localparam logic [7:0]  RST_RX_PD     = 8'h00;
    localparam logic [7:0]  RST_RX_PU     = 8'hff;
    localparam logic [7:0]  RST_TX_PD     = 8'hd0;
    localparam logic [7:0]  RST_TX_PU     = 8'hff;
    // outputs start at the decode of the reset pairs: all off, pll held in reset
    localparam logic [11:0] RST_CIRCUIT_EN  = 12'h000;
    localparam logic        RST_SYNTH_RESET = 1'b1;

    // bit positions inside the pll group pair
    localparam int unsigned BIT_SYNTH_RESET   = 4;
    localparam int unsigned BIT_OSC_BUFFER    = 3;
    localparam int unsigned BIT_OSC           = 2;
    localparam int unsigned BIT_FREQ_DIVIDER  = 1;
    localparam int unsigned BIT_CHARGE_PUMP   = 0;
    // bit positions inside the receive pair
    localparam int unsigned BIT_LOW_NOISE_AMP = 7;
    localparam int unsigned BIT_RX_MIXER      = 6;
    localparam int unsigned BIT_BASEBAND_AMP  = 5;
    localparam int unsigned BIT_RX_MIXER_BUF  = 4;
    localparam int unsigned BIT_RX_RESERVED   = 3;
    localparam int unsigned BIT_RX_LOWPASS    = 2;
    localparam int unsigned BIT_GAIN_AMP      = 1;
    localparam int unsigned BIT_RX_CONVERTER  = 0;
    // bit position inside the transmit pair
    localparam int unsigned BIT_TX_UPMIX_BUF  = 5;

    // positions in the circuit enable vector
    localparam int unsigned EN_CHARGE_PUMP    = 0;
    localparam int unsigned EN_FREQ_DIVIDER   = 1;
    localparam int unsigned EN_OSC            = 2;
    localparam int unsigned EN_OSC_BUFFER     = 3;
    localparam int unsigned EN_RX_CONVERTER   = 4;
    localparam int unsigned EN_GAIN_AMP       = 5;
    localparam int unsigned EN_RX_LOWPASS     = 6;
    localparam int unsigned EN_RX_MIXER_BUF   = 7;
    localparam int unsigned EN_BASEBAND_AMP   = 8;
    localparam int unsigned EN_RX_MIXER       = 9;
    localparam int unsigned EN_LOW_NOISE_AMP  = 10;
    localparam int unsigned EN_TX_UPMIX_BUF   = 11;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } rfpo_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } rfpo_axi_rsp_type;

    // 1/1 follows the sequencer, 0/1 forces off, anything else forces on
    function automatic logic rfpo_pair_enable(input logic pd, input logic pu, input logic modem);
        rfpo_pair_enable = (pd & pu) ? modem : ~(~pd & pu);
    endfunction

endpackage

/* tb/rfpo_modem_model.sv */
// behavioural modem sequencer driving per-circuit enables and the synth reset
`timescale 1ns/1ps
module rfpo_modem_model (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        slow,
    input  wire logic [12:0] target,
    output      logic [11:0] modemEnable_ff,
    output      logic        modemSynthReset_ff
);
    logic [12:0] stage_ff;
    logic [12:0] nxt_out;

    // slow mode lags one more cycle, like a sequencer still settling
    always_comb begin
        nxt_out = slow ? stage_ff : target;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stage_ff           <= 13'h0000;
            modemEnable_ff     <= 12'h000;
            modemSynthReset_ff <= 1'b1;
        end else begin
            stage_ff                             <= target;
            {modemSynthReset_ff, modemEnable_ff} <= nxt_out;
        end
    end
endmodule

/* tb/tb_rf_power_override_regs.sv */
// self-checking bench for the rf power override register bank
`timescale 1ns/1ps
module tb_rf_power_override_regs;
    import rfpo_pkg::*;

    localparam int          LIMIT       = 20000;
    localparam int          MAP_REG [13] = '{0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 2, 0};
    localparam int          MAP_BIT [13] = '{BIT_CHARGE_PUMP, BIT_FREQ_DIVIDER, BIT_OSC,
        BIT_OSC_BUFFER, BIT_RX_CONVERTER, BIT_GAIN_AMP, BIT_RX_LOWPASS, BIT_RX_MIXER_BUF,
        BIT_BASEBAND_AMP, BIT_RX_MIXER, BIT_LOW_NOISE_AMP, BIT_TX_UPMIX_BUF, BIT_SYNTH_RESET};
    localparam logic [31:0] OFS [6]     = '{OFS_PLL_PD, OFS_PLL_PU, OFS_RX_PD, OFS_RX_PU,
        OFS_TX_PD, OFS_TX_PU};
    localparam logic [7:0]  RST [6]     = '{RST_PLL_PD, RST_PLL_PU, RST_RX_PD, RST_RX_PU,
        RST_TX_PD, RST_TX_PU};

    logic             clock;
    logic             rst_b;
    rfpo_axi_req_type axiReq;
    rfpo_axi_rsp_type axiRsp;
    logic [11:0]      modemEnable;
    logic             modemSynthReset;
    logic [11:0]      circuitEnable;
    logic             synthReset;
    logic             slow;
    logic [12:0]      target;
    logic [7:0]       pdReg [3];
    logic [7:0]       puReg [3];
    logic [31:0]      rd;
    logic [1:0]       resp;
    logic [11:0]      expEn;
    logic             expRst;
    logic             pd;
    logic             pu;
    int               c;
    int               err_count;
    int               check_count;
    int               cycles;

    rfpo_regs uut (.clock(clock), .rst_b(rst_b), .axiReq(axiReq), .axiRsp(axiRsp),
        .modemEnable(modemEnable), .modemSynthReset(modemSynthReset),
        .circuitEnable_ff(circuitEnable), .synthReset_ff(synthReset));

    rfpo_modem_model seq (.clock(clock), .rst_b(rst_b), .slow(slow), .target(target),
        .modemEnable_ff(modemEnable), .modemSynthReset_ff(modemSynthReset));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // hang guard: a stuck handshake ends the run as a failure
    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            conclude();
        end
    end

    task automatic conclude();
        $display("mismatches %0d comparisons %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic checkEn(input string name, input int pos);
        check(name, {31'h0, expEn[pos]}, {31'h0, circuitEnable[pos]});
    endtask

    task automatic axiWrite(input logic [31:0] addr, input logic [7:0] data,
                            input logic [3:0] strb, input logic [1:0] expResp);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone  = 1'b0;
        @(posedge clock);
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr  <= addr;
        axiReq.wvalid  <= 1'b1;
        axiReq.wdata   <= {24'h0, data};
        axiReq.wstrb   <= strb;
        axiReq.bready  <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge clock);
            if (!awDone && axiRsp.awready === 1'b1) begin
                awDone = 1'b1;
                axiReq.awvalid <= 1'b0;
            end
            if (!wDone && axiRsp.wready === 1'b1) begin
                wDone = 1'b1;
                axiReq.wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (axiRsp.bvalid !== 1'b1);
        axiReq.bready <= 1'b0;
        check("bresp", {30'h0, expResp}, {30'h0, axiRsp.bresp});
    endtask

    task automatic readCheck(input string name, input logic [31:0] addr,
                             input logic [7:0] exp, input logic [1:0] expResp);
        @(posedge clock);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr  <= addr;
        axiReq.rready  <= 1'b1;
        do @(posedge clock); while (axiRsp.arready !== 1'b1);
        axiReq.arvalid <= 1'b0;
        do @(posedge clock); while (axiRsp.rvalid !== 1'b1);
        rd   = axiRsp.rdata;
        resp = axiRsp.rresp;
        axiReq.rready <= 1'b0;
        check(name, {24'h0, exp}, rd);
        check({name, "_resp"}, {30'h0, expResp}, {30'h0, resp});
    endtask

    initial begin
        rst_b  = 1'b0;
        axiReq = '0;
        slow   = 1'b0;
        target = 13'h0000;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        // reset pairs are 0/1: every circuit forced off, pll held in reset
        check("enables_reset", 32'h0000_0000, {20'h0, circuitEnable});
        check("synth_reset_reset", 32'h1, {31'h0, synthReset});
        for (int r = 0; r < 6; r++) readCheck("reset_value", OFS[r], RST[r], RESP_OKAY);
        // every circuit walks through all four pairs, each at a different step
        for (int k = 0; k < 4; k++) begin
            // reserved receive bit kept at zero
            pdReg = '{RST_PLL_PD, RST_RX_PD, RST_TX_PD};
            puReg = '{8'hff, 8'hff, 8'hff};
            for (int i = 0; i < 13; i++) begin
                c = (i + k) % 4;
                pdReg[MAP_REG[i]][MAP_BIT[i]] = c[1];
                puReg[MAP_REG[i]][MAP_BIT[i]] = c[0];
            end
            for (int r = 0; r < 3; r++) begin
                axiWrite(OFS[2*r], pdReg[r], 4'hf, RESP_OKAY);
                axiWrite(OFS[2*r+1], puReg[r], 4'hf, RESP_OKAY);
            end
            for (int p = 0; p < 2; p++) begin
                target <= (p == 0) ? 13'h0a5c : 13'h15a3;
                slow   <= p[0];
                repeat (5) @(posedge clock);
                for (int i = 0; i < 13; i++) begin
                    pd = pdReg[MAP_REG[i]][MAP_BIT[i]];
                    pu = puReg[MAP_REG[i]][MAP_BIT[i]];
                    if (i < 12) expEn[i] = (pd & pu) ? target[i] : ~(~pd & pu);
                    else expRst = (pd & pu) ? target[i] : (~pd & pu);
                end
                check("enables", {20'h0, expEn}, {20'h0, circuitEnable}); // to
                checkEn("osc_buffer", EN_OSC_BUFFER);
                checkEn("divider", EN_FREQ_DIVIDER);
                checkEn("charge_pump", EN_CHARGE_PUMP);
                checkEn("low_noise_amp", EN_LOW_NOISE_AMP);
                checkEn("baseband_amp", EN_BASEBAND_AMP);
                checkEn("rx_mixer", EN_RX_MIXER);
                checkEn("rx_mixer_buf", EN_RX_MIXER_BUF);
                checkEn("gain_amp", EN_GAIN_AMP);
                checkEn("rx_converter", EN_RX_CONVERTER);
                checkEn("tx_upmix_buf", EN_TX_UPMIX_BUF);
                check("synth_reset", {31'h0, expRst}, {31'h0, synthReset});
            end
            for (int r = 0; r < 3; r++) begin
                readCheck("readback", OFS[2*r], pdReg[r], RESP_OKAY);
            end
        end
        axiWrite(32'h0000_0018, 8'h55, 4'hf, RESP_SLVERR);
        readCheck("unmapped", 32'h0000_0018, 8'h00, RESP_SLVERR);
        readCheck("misaligned", 32'h0000_0002, 8'h00, RESP_SLVERR);
        axiWrite(OFS_PLL_PD, 8'h00, 4'he, RESP_OKAY);
        readCheck("strobe_masked", OFS_PLL_PD, pdReg[0], RESP_OKAY);
        // power-up already 1, so setting power-down hands the amp back to the sequencer
        axiWrite(OFS_RX_PD, 8'h80, 4'hf, RESP_OKAY);
        repeat (5) @(posedge clock);
        expEn[EN_LOW_NOISE_AMP] = target[EN_LOW_NOISE_AMP];
        checkEn("low_noise_modem", EN_LOW_NOISE_AMP);
        conclude();
    end
endmodule
